// ===== src/bac_defs.vh
// constants for the buffer address, byte and load counters
`ifndef BAC_DEFS_VH
`define BAC_DEFS_VH
`define BAC_CLK_NS 20
`define BAC_LATCH_SET_NS 30
`define BAC_LATCH_SET_CYC ((`BAC_LATCH_SET_NS + `BAC_CLK_NS - 1) / `BAC_CLK_NS)
`define BAC_REG_CTRL 4'h0
`define BAC_REG_ADDR 4'h4
`define BAC_REG_COUNT 4'h8
`define BAC_REG_SENSE 4'hC
`define BAC_CTRL_BUF_OPT 0
`define BAC_CTRL_OFFLINE 1
`define BAC_CTRL_READ_BTN 2
`define BAC_CTRL_RESET 2'h0
`define BAC_LATCH_LSB 16
`define BAC_LOAD_LSB 8
`define BAC_RESP_OKAY 2'h0
`define BAC_RESP_DECERR 2'h3
`endif

// ===== src/bac_counters.v
// buffer address counter, address latch, byte counter and load counter
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "bac_defs.vh"

module bac_counters #(
  parameter ADDR_W = 14,
  parameter BYTE_W = 3,
  parameter LOAD_W = 2
) (
  // clock and machine reset
  input wire ref_clk,
  input wire srst,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timing pulses
  input wire timing_pulse_nine,
  input wire timing_pulse_ten,
  input wire timing_pulse_nineteen,
  // address counter control
  input wire address_step_pulse,
  input wire count_up_gate,
  input wire count_down_gate,
  input wire address_step_latch,
  input wire address_plus_one_latch,
  input wire address_clear,
  input wire set_address_command,
  input wire channel_bytes_load,
  input wire [7:0] channel_byte_high,
  input wire [7:0] channel_byte_low,
  input wire b_register_load,
  input wire [ADDR_W-1:0] b_register,
  // byte counter control
  input wire end_of_search_proceed,
  input wire data_proceed,
  input wire character_mode,
  input wire graphic_order,
  input wire character_order,
  input wire transfer_order,
  input wire stroke_mode_search_pen_hit,
  input wire preceding_graphic_mode,
  input wire pen_detect_trigger,
  input wire counter_sample,
  input wire remembered_search,
  // load counter control
  input wire early_status,
  input wire service_out,
  input wire command_accept,
  input wire command_completed,
  input wire timing_period_three,
  input wire timing_period_four,
  input wire word_hold,
  input wire set_function_key_lights,
  input wire read_manual_inputs,
  input wire read_position,
  input wire sense_command,
  // counter outputs
  output reg [ADDR_W-1:0] buffer_address_counter,
  output reg [ADDR_W-1:0] address_latch,
  output reg read_start,
  output reg [BYTE_W-1:0] byte_count,
  output reg [LOAD_W-1:0] load_count
);

  localparam [2:0] LT_IDLE = 3'b001;
  localparam [2:0] LT_CLEAR = 3'b010;
  localparam [2:0] LT_SET = 3'b100;
  localparam [31:0] SET_CYC_FULL = `BAC_LATCH_SET_CYC;
  localparam [1:0] SET_CYC = SET_CYC_FULL[1:0];

  reg [1:0] ctrl;
  reg read_btn;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg aw_ok;
  reg w_ok;
  reg [2:0] lt_state;
  reg [1:0] lt_cnt;
  reg pen_search;
  reg [BYTE_W-1:0] next_byte_count;
  reg [LOAD_W-1:0] next_load_count;
  reg [ADDR_W-1:0] next_address;
  reg [31:0] rd_word;
  reg rd_hit;

  wire buffer_option = ctrl[`BAC_CTRL_BUF_OPT];
  wire offline = ctrl[`BAC_CTRL_OFFLINE];
  wire start_strobe = timing_pulse_nine | read_btn;

  function is_count;
    input [BYTE_W-1:0] value;
    input [BYTE_W-1:0] target;
    begin
      is_count = (value == target);
    end
  endfunction

  // address counter next value, priority clear, load, up, down
  always @*
  begin
    next_address = buffer_address_counter;
    if (address_clear)
      next_address = {ADDR_W{1'b0}};
    // high byte bits 5:0 weigh 8192 down to 256
    else if (set_address_command && channel_bytes_load)
      next_address = {channel_byte_high[ADDR_W-9:0], channel_byte_low};
    else if (transfer_order && b_register_load)
      next_address = b_register;
    else if ((address_step_pulse && count_up_gate)
      || (timing_pulse_ten && address_step_latch)
      || (timing_pulse_nineteen && address_plus_one_latch)
      || (read_btn && offline))
      next_address = buffer_address_counter + 1'b1;
    else if (address_step_pulse && count_down_gate)
      next_address = buffer_address_counter - 1'b1;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      buffer_address_counter <= {ADDR_W{1'b0}};
    else
      buffer_address_counter <= next_address;
  end

  // latch load: clear phase, then set phase samples the counter
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      lt_state <= LT_IDLE;
      lt_cnt <= 2'h0;
      address_latch <= {ADDR_W{1'b0}};
      // machine reset counts as a start strobe
      read_start <= 1'b1;
    end
    else
    begin
      read_start <= start_strobe;
      // a new start strobe restarts the clear phase
      if (start_strobe)
      begin
        address_latch <= {ADDR_W{1'b0}};
        lt_state <= LT_CLEAR;
        lt_cnt <= SET_CYC - 2'h1;
      end
      else
      begin
        case (lt_state)
          LT_IDLE:
          begin
            lt_cnt <= 2'h0;
          end
          LT_CLEAR:
          begin
            // clear phase lasts the set delay, set lands two edges after the strobe
            if (lt_cnt <= 2'h1)
              lt_state <= LT_SET;
            else
              lt_cnt <= lt_cnt - 2'h1;
          end
          LT_SET:
          begin
            address_latch <= buffer_address_counter;
            lt_state <= LT_IDLE;
          end
          default:
          begin
            lt_state <= LT_IDLE;
          end
        endcase
      end
    end
  end

  // byte counter
  // clears win over every step
  always @*
  begin
    next_byte_count = byte_count;
    if (end_of_search_proceed
      || (graphic_order && data_proceed && is_count(byte_count, 3'h3))
      || stroke_mode_search_pen_hit
      || (counter_sample && is_count(byte_count, 3'h6))
      || (character_order && buffer_option)
      || (transfer_order && data_proceed && buffer_option
        && is_count(byte_count, 3'h1)))
      next_byte_count = {BYTE_W{1'b0}};
    else if (graphic_order && buffer_option && pen_detect_trigger && counter_sample
      && ((!is_count(byte_count, 3'h3) && !is_count(byte_count, 3'h6))
        || (is_count(byte_count, 3'h3) && !remembered_search)))
      next_byte_count = byte_count + 1'b1;
    else if (data_proceed && !character_mode && !character_order
      && !is_count(byte_count, 3'h3)
      && (!pen_search || preceding_graphic_mode))
      next_byte_count = byte_count + 1'b1;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      byte_count <= {BYTE_W{1'b0}};
      pen_search <= 1'b0;
    end
    else
    begin
      byte_count <= next_byte_count;
      // remembers a search pen hit until its stepping ends
      if (stroke_mode_search_pen_hit)
        pen_search <= 1'b1;
      else if (end_of_search_proceed
        || (graphic_order && data_proceed && is_count(byte_count, 3'h3)))
        pen_search <= 1'b0;
    end
  end

  // load counter
  // clears win over steps
  always @*
  begin
    next_load_count = load_count;
    if ((early_status && service_out && command_accept)
      || command_completed)
      next_load_count = {LOAD_W{1'b0}};
    else if ((timing_period_four && set_address_command && buffer_option
        && load_count == 2'h0)
      || (timing_period_four && set_function_key_lights
        && load_count != 2'h3)
      || (timing_period_three && word_hold
        && ((read_manual_inputs && load_count != 2'h2)
          || ((read_position || sense_command) && load_count != 2'h3))))
      next_load_count = load_count + 1'b1;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      load_count <= {LOAD_W{1'b0}};
    else
      load_count <= next_load_count;
  end

  // register read decode
  // unmapped offsets answer with a decode error
  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `BAC_REG_CTRL:
        rd_word[1:0] = ctrl;
      `BAC_REG_ADDR:
      begin
        rd_word[ADDR_W-1:0] = buffer_address_counter;
        rd_word[`BAC_LATCH_LSB +: ADDR_W] = address_latch;
      end
      `BAC_REG_COUNT:
      begin
        rd_word[BYTE_W-1:0] = byte_count;
        rd_word[`BAC_LOAD_LSB +: LOAD_W] = load_count;
      end
      `BAC_REG_SENSE:
      begin
        // third and fourth sense bytes
        rd_word[7:0] = buffer_address_counter[7:0];
        rd_word[13:8] = buffer_address_counter[13:8];
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // axi4-lite slave
  // readies stay low from take until the response handshake
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BAC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BAC_RESP_OKAY;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `BAC_CTRL_RESET;
      read_btn <= 1'b0;
    end
    else
    begin
      read_btn <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_ok <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_ok <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_ok && w_ok && !s_axi_bvalid)
      begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BAC_RESP_OKAY;
        case (aw_addr)
          `BAC_REG_CTRL:
          begin
            if (w_strb[0])
            begin
              ctrl <= w_data[1:0];
              read_btn <= w_data[`BAC_CTRL_READ_BTN];
            end
          end
          `BAC_REG_ADDR, `BAC_REG_COUNT, `BAC_REG_SENSE:
            s_axi_bresp <= `BAC_RESP_OKAY;
          default:
            s_axi_bresp <= `BAC_RESP_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `BAC_RESP_OKAY : `BAC_RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // bac_counters

// ===== verif/bac_chk_checker.sv
// port assertions for the counter block
module bac_chk (
  // clock and reset
  input logic ref_clk,
  input logic srst,
  // watched inputs
  input logic timing_pulse_nine,
  input logic address_step_pulse,
  input logic count_up_gate,
  input logic address_clear,
  input logic channel_bytes_load,
  input logic b_register_load,
  input logic data_proceed,
  input logic graphic_order,
  input logic counter_sample,
  input logic early_status,
  input logic service_out,
  input logic command_accept,
  input logic command_completed,
  // watched outputs
  input logic [13:0] buffer_address_counter,
  input logic [13:0] address_latch,
  input logic read_start,
  input logic [2:0] byte_count,
  input logic [1:0] load_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic quiet;
  assign quiet = !address_clear && !channel_bytes_load && !b_register_load;
  a_latch_clear: assert property (
    timing_pulse_nine |=> address_latch == 14'h0 && read_start)
    else $error("latch not cleared");
  a_latch_set: assert property (
    timing_pulse_nine ##1 !timing_pulse_nine [*2] |=>
    address_latch == $past(buffer_address_counter))
    else $error("latch not set");
  a_step_up: assert property (
    address_step_pulse && count_up_gate && quiet |=>
    buffer_address_counter == $past(buffer_address_counter) + 14'h1)
    else $error("no step up");
  a_addr_clear: assert property (
    address_clear |=> buffer_address_counter == 14'h0)
    else $error("no clear");
  a_byte_end: assert property (
    data_proceed && graphic_order && byte_count == 3'h3 |=> byte_count == 3'h0)
    else $error("no end clear");
  a_byte_final: assert property (
    counter_sample && byte_count == 3'h6 |=> byte_count == 3'h0)
    else $error("no final clear");
  a_load_init: assert property (
    early_status && service_out && command_accept |=> load_count == 2'h0)
    else $error("no load clear");
  a_load_final: assert property (
    command_completed |=> load_count == 2'h0)
    else $error("no final load clear");
  c_six: cover property (byte_count == 3'h6);
  c_three: cover property (load_count == 2'h3);
  c_read: cover property (timing_pulse_nine ##2 read_start == 1'b0);
endmodule // bac_chk

// ===== verif/bac_timing.sv
// stand-in timing generator: one buffer cycle of twenty clocks
module bac_timing (
  // clock and reset
  input logic ref_clk,
  input logic srst,
  // cycle runs while high
  input logic run,
  // single-cycle timing outputs
  output logic timing_pulse_nine,
  output logic timing_pulse_ten,
  output logic timing_pulse_nineteen,
  output logic timing_period_three,
  output logic timing_period_four
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] step;
  always @(posedge ref_clk)
  begin
    if (srst || !run || step == 5'h13)
      step <= 5'h0;
    else
      step <= step + 5'h1;
  end
  assign timing_pulse_nine = run && step == 5'h09;
  assign timing_pulse_ten = run && step == 5'h0A;
  assign timing_pulse_nineteen = run && step == 5'h13;
  assign timing_period_three = run && step == 5'h03;
  assign timing_period_four = run && step == 5'h04;
endmodule // bac_timing

// ===== verif/bac_bench.sv
// self-checking bench for the counter block
module buffer_address_and_sequence_counters_bench;
  timeunit 1ns;
  timeprecision 1ps;
  bit ref_clk, srst, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  bit [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  bit [31:0] s_axi_wdata;
  bit [13:0] b_register;
  bit [7:0] channel_byte_high, channel_byte_low;
  bit address_step_pulse, count_up_gate, count_down_gate, address_step_latch;
  bit address_plus_one_latch, address_clear, set_address_command, channel_bytes_load;
  bit b_register_load, end_of_search_proceed, data_proceed, character_mode;
  bit graphic_order, character_order, transfer_order, stroke_mode_search_pen_hit;
  bit preceding_graphic_mode, pen_detect_trigger, counter_sample, remembered_search;
  bit early_status, service_out, command_accept, command_completed, word_hold;
  bit set_function_key_lights, read_manual_inputs, read_position, sense_command;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, read_start;
  logic [31:0] s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, load_count, rsp;
  logic [2:0] byte_count;
  logic [13:0] buffer_address_counter, address_latch;
  logic timing_pulse_nine, timing_pulse_ten, timing_pulse_nineteen;
  logic timing_period_three, timing_period_four;
  int miscompares, num_checks, cycles;
  bac_counters u_dut (.*);
  bac_timing u_tim (.*);
  always #10 ref_clk = !ref_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // w picks the strobe, each held for one edge
  task strobe(input int w, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      case (w)
        0: data_proceed <= 1'b1;
        1: {counter_sample, pen_detect_trigger} <= 2'h3;
        2: address_step_pulse <= 1'b1;
        3: end_of_search_proceed <= 1'b1;
        4: channel_bytes_load <= 1'b1;
        5: stroke_mode_search_pen_hit <= 1'b1;
        6: address_clear <= 1'b1;
        7: {early_status, service_out, command_accept} <= 3'h7;
        default: command_completed <= 1'b1;
      endcase
      @(posedge ref_clk);
      {data_proceed, counter_sample, pen_detect_trigger, address_step_pulse} <= 4'h0;
      {end_of_search_proceed, channel_bytes_load, address_clear} <= 3'h0;
      stroke_mode_search_pen_hit <= 1'b0;
      {early_status, service_out, command_accept, command_completed} <= 4'h0;
    end
    #1;
  endtask
  task bus(input bit wr, input bit [3:0] a, input bit [31:0] d);
    bit ta, tw, tr, dn;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    dn = 1'b0;
    while (!dn)
    begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge ref_clk);
      s_axi_awvalid <= s_axi_awvalid && !ta;
      s_axi_wvalid <= s_axi_wvalid && !tw;
      s_axi_arvalid <= s_axi_arvalid && !tr;
      {s_axi_bready, s_axi_rready} <= {s_axi_bready && !dn, s_axi_rready && !dn};
    end
    #1;
  endtask
  task run_for(input int n);
    @(posedge ref_clk);
    run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    run <= 1'b0;
    #1;
  endtask
  task t_address;
    @(posedge ref_clk);
    count_up_gate <= 1'b1;
    strobe(2, 3);
    chk(buffer_address_counter, 32'h3);
    @(posedge ref_clk);
    {count_up_gate, count_down_gate} <= 2'h1;
    strobe(2, 1);
    chk(buffer_address_counter, 32'h2);
    @(posedge ref_clk);
    {count_down_gate, set_address_command} <= 2'h1;
    {channel_byte_high, channel_byte_low} <= 16'hFFFE;
    strobe(4, 1);
    chk(buffer_address_counter, 32'h3FFE);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h3FFE);
    chk(rsp, 32'h0);
    @(posedge ref_clk);
    {count_up_gate, set_address_command} <= 2'h2;
    strobe(2, 3);
    chk(buffer_address_counter, 32'h1);
    strobe(6, 1);
    chk(buffer_address_counter, 32'h0);
    bus(1'b1, 4'h0, 32'h6);
    chk(buffer_address_counter, 32'h1);
    chk(rsp, 32'h0);
  endtask
  task t_timing;
    strobe(2, 1);
    run_for(20);
    chk(address_latch, 32'h2);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0002_0002);
    @(posedge ref_clk);
    {address_step_latch, address_plus_one_latch} <= 2'h3;
    run_for(20);
    chk(buffer_address_counter, 32'h4);
    chk(address_latch, 32'h3);
    @(posedge ref_clk);
    {address_step_latch, address_plus_one_latch} <= 2'h0;
  endtask
  task t_load;
    bus(1'b1, 4'h0, 32'h1);
    @(posedge ref_clk);
    set_address_command <= 1'b1;
    run_for(40);
    chk(load_count, 32'h1);
    strobe(8, 1);
    chk(load_count, 32'h0);
    @(posedge ref_clk);
    {set_address_command, set_function_key_lights} <= 2'h1;
    run_for(100);
    chk(load_count, 32'h3);
    strobe(7, 1);
    chk(load_count, 32'h0);
    @(posedge ref_clk);
    {set_function_key_lights, read_manual_inputs, word_hold} <= 3'h3;
    run_for(80);
    chk(load_count, 32'h2);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0000_0200);
    strobe(8, 1);
    chk(load_count, 32'h0);
  endtask
  task t_byte;
    bus(1'b1, 4'h0, 32'h1);
    strobe(0, 2);
    strobe(3, 1);
    chk(byte_count, 32'h0);
    strobe(0, 4);
    chk(byte_count, 32'h3);
    @(posedge ref_clk);
    graphic_order <= 1'b1;
    strobe(0, 1);
    chk(byte_count, 32'h0);
    strobe(1, 6);
    chk(byte_count, 32'h6);
    strobe(1, 1);
    chk(byte_count, 32'h0);
    @(posedge ref_clk);
    {graphic_order, transfer_order} <= 2'h1;
    strobe(0, 1);
    strobe(3, 1);
    chk(byte_count, 32'h0);
    strobe(0, 1);
    chk(byte_count, 32'h1);
    strobe(0, 1);
    chk(byte_count, 32'h0);
    @(posedge ref_clk);
    transfer_order <= 1'b0;
    strobe(0, 1);
    @(posedge ref_clk);
    character_order <= 1'b1;
    strobe(0, 1);
    chk(byte_count, 32'h0);
    @(posedge ref_clk);
    {character_order, character_mode} <= 2'h1;
    strobe(0, 1);
    chk(byte_count, 32'h0);
    @(posedge ref_clk);
    character_mode <= 1'b0;
    strobe(0, 2);
    strobe(5, 1);
    chk(byte_count, 32'h0);
    strobe(0, 1);
    chk(byte_count, 32'h0);
    @(posedge ref_clk);
    preceding_graphic_mode <= 1'b1;
    strobe(0, 1);
    chk(byte_count, 32'h1);
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      conclude;
    end
  end
  initial
  begin
    srst = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk({address_latch, byte_count, buffer_address_counter}, 32'h0);
    t_address;
    t_timing;
    t_load;
    t_byte;
    conclude;
  end
endmodule // buffer_address_and_sequence_counters_bench
bind bac_counters bac_chk u_chk (.*);
